//--- rtl/tcc_pkg.sv
/*
 * Constants and types of the sixteen-bit capture/compare timer with pulse output.
 * Assumes an APB master with 32-bit data and word-aligned byte addresses.
 */
package tcc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CNT_W  = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
    localparam logic [7:0] OFS_CAPCOMP   = 8'h04;
    localparam logic [7:0] OFS_OUT_CTRL  = 8'h08;
    localparam logic [7:0] OFS_PRESCALER = 8'h0C;
    localparam logic [7:0] OFS_COUNTER   = 8'h10;
    localparam logic [7:0] OFS_CC_A      = 8'h14;
    localparam logic [7:0] OFS_CC_B      = 8'h18;

    // Mode control fields
    localparam int unsigned MODE_LSB  = 2;
    localparam int unsigned TOGE_BIT  = 1;
    localparam int unsigned OVF_BIT   = 0;
    localparam logic [1:0]  MODE_STOP = 2'h0;
    localparam logic [1:0]  MODE_FREE = 2'h1;
    localparam logic [1:0]  MODE_PPG  = 2'h3;

    // Capture/compare control fields
    localparam int unsigned A_CAP_BIT    = 0;
    localparam int unsigned A_TRIG_A_BIT = 1;
    localparam int unsigned B_CAP_BIT    = 2;

    // Output control fields
    localparam int unsigned OUT_EN_BIT = 0;

    // Prescaler fields and codes
    localparam int unsigned B_EDGE_LSB = 5;
    localparam int unsigned A_EDGE_LSB = 3;
    localparam logic [1:0]  EDGE_FALL  = 2'h0;
    localparam logic [1:0]  EDGE_RISE  = 2'h1;
    localparam logic [1:0]  EDGE_NONE  = 2'h2;
    localparam logic [1:0]  EDGE_BOTH  = 2'h3;
    localparam logic [1:0]  CLK_DIV1   = 2'h0;
    localparam logic [1:0]  CLK_DIV2   = 2'h1;
    localparam logic [1:0]  CLK_DIV4   = 2'h2;
    localparam logic [1:0]  CLK_HOLD   = 2'h3;

    // Reset values and counting constants
    localparam logic [7:0]       RST_BYTE = 8'h00;
    localparam logic [CNT_W-1:0] RST_WORD = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [1:0]       PRE_ONE  = 2'h1;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } tcc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tcc_apb_rsp_t;

    typedef struct packed {
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [1:0] pre_cnt;
        logic [7:0] mode_ctrl;
        logic [7:0] capcomp;
        logic [7:0] out_ctrl;
        logic [7:0] prescaler;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] cc_a;
        logic [CNT_W-1:0] cc_b;
        logic       out_lvl;
        logic       irq_a;
        logic       irq_b;
        tcc_apb_rsp_t rsp;
    } tcc_state_t;

endpackage

//--- rtl/tcc_timer.sv
/*
 * Sixteen-bit capture/compare timer with free-running and pulse-generation modes.
 * Assumes trigger inputs are asynchronous pins and the APB master follows the usual protocol.
 */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Reading the counter register returns the current sixteen-bit count.
// - Compare A equal to counter raises match A interrupt; counter keeps running.
// - Capture A takes the count on the chosen trigger input's valid edge.
// - Compare B equal to counter raises match B interrupt; counter keeps running.
// - Capture B takes the count on trigger input A's valid edge only.
// - Mode code 01 counts up by one on every count tick.
// - After the maximum count, next tick sets overflow and wraps to zero.
// - In free-running mode each register is independently compare or capture.
// - With both compares, each match toggles output and raises its interrupt.
// - Capture B in free-running mode also raises the match B interrupt.
// - Both capture: output holds, unless toggle-on-edge bit makes input A edges toggle.
// - Both capture: edge A captures into B, the chosen trigger input's edge into A.
// - Both capture with only input B edges enabled: no captures into B.
// - Mode code 11 clears counter on match A; output is period-A, width-B wave.
// - Period is A plus one ticks; high time is B plus one ticks.
// - Trigger B valid edge is selected by prescaler bits 6 and 5.
module tcc_timer (
    input  wire logic                       ref_clk_i,
    input  wire logic                       reset_i,
    input  wire tcc_pkg::tcc_apb_req_t      apb_req_i,
    output var  tcc_pkg::tcc_apb_rsp_t      apb_rsp_o,
    input  wire logic                       trigger_input_a_i,
    input  wire logic                       trigger_input_b_i,
    output logic                            timer_output_pin_o,
    output logic                            match_a_irq_o,
    output logic                            match_b_irq_o
);

    tcc_pkg::tcc_state_t s_q;
    tcc_pkg::tcc_state_t s_d;

    logic                     tick;
    logic                     edge_a;
    logic                     edge_b;
    logic [1:0]               mode;
    logic                     a_cap;
    logic                     b_cap;
    logic                     match_a;
    logic                     match_b;
    logic                     cap_a;
    logic                     cap_b;
    logic                     access;

    // Valid-edge test on the agreeing synchroniser stages only
    function automatic logic valid_edge(input logic [2:0] sy, input logic [1:0] sel);
        logic rise;
        logic fall;
        rise = sy[1] & ~sy[2];
        fall = ~sy[1] & sy[2];
        case (sel)
            tcc_pkg::EDGE_FALL: valid_edge = fall;
            tcc_pkg::EDGE_RISE: valid_edge = rise;
            tcc_pkg::EDGE_BOTH: valid_edge = rise | fall;
            default:            valid_edge = 1'b0;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    always_comb begin
        mode   = s_q.mode_ctrl[tcc_pkg::MODE_LSB +: 2];
        a_cap  = s_q.capcomp[tcc_pkg::A_CAP_BIT] && (mode == tcc_pkg::MODE_FREE);
        b_cap  = s_q.capcomp[tcc_pkg::B_CAP_BIT] && (mode == tcc_pkg::MODE_FREE);
        edge_a = valid_edge(s_q.sync_a, s_q.prescaler[tcc_pkg::A_EDGE_LSB +: 2]);
        edge_b = valid_edge(s_q.sync_b, s_q.prescaler[tcc_pkg::B_EDGE_LSB +: 2]);
        case (s_q.prescaler[1:0])
            tcc_pkg::CLK_DIV1: tick = 1'b1;
            tcc_pkg::CLK_DIV2: tick = s_q.pre_cnt[0];
            tcc_pkg::CLK_DIV4: tick = &s_q.pre_cnt;
            default:           tick = 1'b0;
        endcase
        if (mode != tcc_pkg::MODE_FREE && mode != tcc_pkg::MODE_PPG) begin
            tick = 1'b0;
        end
        match_a = tick && !a_cap && (s_q.cnt == s_q.cc_a);
        match_b = tick && !b_cap && (s_q.cnt == s_q.cc_b);
        cap_a   = a_cap && (s_q.capcomp[tcc_pkg::A_TRIG_A_BIT] ? edge_a : edge_b);
        cap_b   = b_cap && edge_a;
        access  = apb_req_i.psel && apb_req_i.penable && !s_q.rsp.pready;
    end

    always_comb begin
        s_d = s_q;
        s_d.sync_a  = {s_q.sync_a[1:0], trigger_input_a_i};
        s_d.sync_b  = {s_q.sync_b[1:0], trigger_input_b_i};
        s_d.pre_cnt = s_q.pre_cnt + tcc_pkg::PRE_ONE;
        s_d.irq_a   = match_a || cap_a;
        s_d.irq_b   = match_b || cap_b;

        // Register access, one wait state; hardware events below override writes
        s_d.rsp.pready  = access;
        s_d.rsp.pslverr = 1'b0;
        s_d.rsp.prdata  = '0;
        if (access) begin
            if (apb_req_i.pwrite) begin
                if (hit(apb_req_i.paddr, tcc_pkg::OFS_MODE_CTRL)) begin
                    s_d.mode_ctrl = apb_req_i.pwdata[7:0];
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_CAPCOMP)) begin
                    s_d.capcomp = apb_req_i.pwdata[7:0];
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_OUT_CTRL)) begin
                    s_d.out_ctrl = apb_req_i.pwdata[7:0];
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_PRESCALER)) begin
                    s_d.prescaler = apb_req_i.pwdata[7:0];
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_CC_A)) begin
                    s_d.cc_a = apb_req_i.pwdata[15:0];
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_CC_B)) begin
                    s_d.cc_b = apb_req_i.pwdata[15:0];
                end else if (!hit(apb_req_i.paddr, tcc_pkg::OFS_COUNTER)) begin
                    s_d.rsp.pslverr = 1'b1;
                end
            end else begin
                if (hit(apb_req_i.paddr, tcc_pkg::OFS_MODE_CTRL)) begin
                    s_d.rsp.prdata[7:0] = s_q.mode_ctrl;
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_CAPCOMP)) begin
                    s_d.rsp.prdata[7:0] = s_q.capcomp;
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_OUT_CTRL)) begin
                    s_d.rsp.prdata[7:0] = s_q.out_ctrl;
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_PRESCALER)) begin
                    s_d.rsp.prdata[7:0] = s_q.prescaler;
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_COUNTER)) begin
                    s_d.rsp.prdata[15:0] = s_q.cnt;
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_CC_A)) begin
                    s_d.rsp.prdata[15:0] = s_q.cc_a;
                end else if (hit(apb_req_i.paddr, tcc_pkg::OFS_CC_B)) begin
                    s_d.rsp.prdata[15:0] = s_q.cc_b;
                end else begin
                    s_d.rsp.pslverr = 1'b1;
                end
            end
        end

        // Counter
        if (s_q.prescaler[1:0] == tcc_pkg::CLK_HOLD || mode == tcc_pkg::MODE_STOP) begin
            s_d.cnt = tcc_pkg::RST_WORD;
        end else if (tick) begin
            if (mode == tcc_pkg::MODE_PPG && s_q.cnt == s_q.cc_a) begin
                s_d.cnt = tcc_pkg::RST_WORD;
            end else begin
                s_d.cnt = s_q.cnt + tcc_pkg::CNT_ONE;
            end
            if (mode == tcc_pkg::MODE_FREE && s_q.cnt == tcc_pkg::CNT_MAX) begin
                s_d.mode_ctrl[tcc_pkg::OVF_BIT] = 1'b1;
            end
        end

        // Captures win over a same-cycle register write
        if (cap_a) begin
            s_d.cc_a = s_q.cnt;
        end
        if (cap_b) begin
            s_d.cc_b = s_q.cnt;
        end

        // Output pin; disabled output parks low
        if (!s_q.out_ctrl[tcc_pkg::OUT_EN_BIT]) begin
            s_d.out_lvl = 1'b0;
        end else if (mode == tcc_pkg::MODE_PPG) begin
            if (match_b) begin
                s_d.out_lvl = 1'b0;
            end else if (match_a) begin
                s_d.out_lvl = 1'b1;
            end
        end else if (mode == tcc_pkg::MODE_FREE) begin
            if (a_cap && b_cap) begin
                if (s_q.mode_ctrl[tcc_pkg::TOGE_BIT] && edge_a) begin
                    s_d.out_lvl = ~s_q.out_lvl;
                end
            end else if (match_a ^ match_b) begin
                s_d.out_lvl = ~s_q.out_lvl;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp_o          = s_q.rsp;
    assign timer_output_pin_o = s_q.out_lvl;
    assign match_a_irq_o      = s_q.irq_a;
    assign match_b_irq_o      = s_q.irq_b;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    logic rd_cnt;
    assign rd_cnt = access && !apb_req_i.pwrite && hit(apb_req_i.paddr, tcc_pkg::OFS_COUNTER);

    // Writes that may legally move a register with no hardware event
    logic wr_mode;
    logic wr_cc_a;
    logic wr_cc_b;
    assign wr_mode = access && apb_req_i.pwrite && hit(apb_req_i.paddr, tcc_pkg::OFS_MODE_CTRL);
    assign wr_cc_a = access && apb_req_i.pwrite && hit(apb_req_i.paddr, tcc_pkg::OFS_CC_A);
    assign wr_cc_b = access && apb_req_i.pwrite && hit(apb_req_i.paddr, tcc_pkg::OFS_CC_B);

    sequence ppg_wrap;
        tick && mode == tcc_pkg::MODE_PPG && s_q.cnt == s_q.cc_a && s_q.cnt != s_q.cc_b
            && s_q.out_ctrl[tcc_pkg::OUT_EN_BIT];
    endsequence
    sequence ppg_high_start;
        s_q.cnt == tcc_pkg::RST_WORD && timer_output_pin_o;
    endsequence
    sequence free_match_event;
        mode == tcc_pkg::MODE_FREE && !(a_cap && b_cap) && (match_a ^ match_b)
            && s_q.out_ctrl[tcc_pkg::OUT_EN_BIT];
    endsequence
    sequence both_cap_edge;
        a_cap && b_cap && s_q.mode_ctrl[tcc_pkg::TOGE_BIT] && edge_a && s_q.out_ctrl[tcc_pkg::OUT_EN_BIT];
    endsequence
    sequence pin_flipped;
        timer_output_pin_o != $past(timer_output_pin_o);
    endsequence

    chk_counter_read_value: assert property (rd_cnt |=> apb_rsp_o.pready && apb_rsp_o.prdata == {16'h0000, $past(s_q.cnt)})
        else $error("counter read returned wrong value");
    chk_match_a_irq: assert property (tick && !a_cap && s_q.cnt == s_q.cc_a |=> match_a_irq_o
        && (s_q.cnt != tcc_pkg::RST_WORD || $past(mode) == tcc_pkg::MODE_PPG
            || $past(s_q.cnt) == tcc_pkg::CNT_MAX))
        else $error("match A interrupt missing or counter cleared");
    chk_capture_a_value: assert property (cap_a |=> s_q.cc_a == $past(s_q.cnt) && match_a_irq_o)
        else $error("capture A did not store the count");
    chk_match_b_irq: assert property (tick && !b_cap && s_q.cnt == s_q.cc_b |=> match_b_irq_o)
        else $error("match B interrupt missing");
    chk_capture_b_value: assert property (b_cap && edge_a |=> s_q.cc_b == $past(s_q.cnt) && match_b_irq_o)
        else $error("capture B did not store the count");
    chk_free_count_step: assert property (tick && mode == tcc_pkg::MODE_FREE
        && s_q.cnt != tcc_pkg::CNT_MAX && s_q.prescaler[1:0] != tcc_pkg::CLK_HOLD
        |=> s_q.cnt == $past(s_q.cnt) + tcc_pkg::CNT_ONE)
        else $error("free-running counter did not step by one");
    chk_overflow_wrap: assert property (tick && mode == tcc_pkg::MODE_FREE
        && s_q.cnt == tcc_pkg::CNT_MAX |=> s_q.mode_ctrl[tcc_pkg::OVF_BIT] && s_q.cnt == tcc_pkg::RST_WORD)
        else $error("overflow not flagged at wrap");
    chk_ppg_restart: assert property (ppg_wrap |=> ppg_high_start)
        else $error("pulse mode did not restart high at zero");
    chk_ppg_width_end: assert property (tick && mode == tcc_pkg::MODE_PPG
        && s_q.cnt == s_q.cc_b && s_q.cnt != s_q.cc_a |=> !timer_output_pin_o)
        else $error("pulse did not end after B plus one ticks");
    chk_clock_hold_clear: assert property (s_q.prescaler[1:0] == tcc_pkg::CLK_HOLD |=> s_q.cnt == tcc_pkg::RST_WORD)
        else $error("counter not held cleared");
    chk_both_capture_hold: assert property (a_cap && b_cap
        && !(s_q.mode_ctrl[tcc_pkg::TOGE_BIT] && edge_a) && s_q.out_ctrl[tcc_pkg::OUT_EN_BIT]
        |=> $stable(timer_output_pin_o))
        else $error("output toggled in both-capture mode");

    // Compare matches leave a free-running count alone
    chk_match_a_no_clear: assert property (tick && !a_cap && mode == tcc_pkg::MODE_FREE
        && s_q.cnt == s_q.cc_a && s_q.cnt != tcc_pkg::CNT_MAX |=> s_q.cnt == $past(s_q.cnt) + tcc_pkg::CNT_ONE)
        else $error("compare A match disturbed the count");
    chk_match_b_no_clear: assert property (tick && !b_cap && mode == tcc_pkg::MODE_FREE
        && s_q.cnt == s_q.cc_b && s_q.cnt != tcc_pkg::CNT_MAX |=> s_q.cnt == $past(s_q.cnt) + tcc_pkg::CNT_ONE)
        else $error("compare B match disturbed the count");
    chk_irq_a_cause: assert property (match_a_irq_o |-> $past(match_a || cap_a))
        else $error("match A interrupt without a match or capture");
    chk_irq_b_cause: assert property (match_b_irq_o |-> $past(match_b || cap_b))
        else $error("match B interrupt without a match or capture");

    // Output pin in free-running mode
    chk_free_match_toggle: assert property (free_match_event |=> pin_flipped)
        else $error("compare match did not toggle the output");
    chk_edge_toggle: assert property (both_cap_edge |=> pin_flipped)
        else $error("input A edge did not toggle the output");

    // Capture register B moves only on an input A edge or a write
    chk_capture_b_only_a: assert property (b_cap && !edge_a && !wr_cc_b |=> $stable(s_q.cc_b))
        else $error("capture B moved without an input A edge");
    chk_no_capture_b_off: assert property (a_cap && b_cap
        && s_q.prescaler[tcc_pkg::A_EDGE_LSB +: 2] == tcc_pkg::EDGE_NONE && !wr_cc_b |=> $stable(s_q.cc_b))
        else $error("capture into B with input A edges off");

    // Sticky flag and pulse-mode bounds
    chk_overflow_sticky: assert property (s_q.mode_ctrl[tcc_pkg::OVF_BIT] && !wr_mode
        |=> s_q.mode_ctrl[tcc_pkg::OVF_BIT])
        else $error("overflow flag cleared by hardware");
    chk_ppg_count_bound: assert property (mode == tcc_pkg::MODE_PPG && s_q.cnt <= s_q.cc_a && !wr_cc_a
        |=> s_q.cnt <= s_q.cc_a)
        else $error("pulse-mode count passed register A");
    chk_ppg_level_hold: assert property (tick && mode == tcc_pkg::MODE_PPG && s_q.out_ctrl[tcc_pkg::OUT_EN_BIT]
        && s_q.cnt != s_q.cc_a && s_q.cnt != s_q.cc_b |=> $stable(timer_output_pin_o))
        else $error("pulse output moved between its edges");

    // Response shape and stopped counter
    chk_ready_pulse: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
        else $error("ready held longer than one cycle");
    chk_idle_response: assert property (!apb_rsp_o.pready |-> apb_rsp_o.prdata == '0 && !apb_rsp_o.pslverr)
        else $error("response data outside a ready cycle");
    chk_stop_cleared: assert property (mode == tcc_pkg::MODE_STOP |=> s_q.cnt == tcc_pkg::RST_WORD)
        else $error("stopped counter not cleared");

endmodule

`default_nettype wire

//--- tb/tb_tcc_timer.sv
/*
 * Self-checking bench for the capture/compare timer, APB master tasks.
 * Assumes the pin model and the timer are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_tcc_timer;
    logic                  ref_clk_i;
    logic                  reset_i;
    tcc_pkg::tcc_apb_req_t req;
    tcc_pkg::tcc_apb_rsp_t rsp;
    logic                  trig_a, trig_b, pin, irq_a, irq_b, a_lvl, b_lvl, err, got, p0;
    logic [15:0]           hi_len, per_len;
    logic [31:0]           rd, c1;
    int                    miscompares = 0;
    int                    tests_run = 0;

    tcc_timer tcc_timer_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .apb_req_i(req), .apb_rsp_o(rsp),
        .trigger_input_a_i(trig_a), .trigger_input_b_i(trig_b), .timer_output_pin_o(pin),
        .match_a_irq_o(irq_a), .match_b_irq_o(irq_b));
    tcc_pins_model tcc_pins_model_i (.ref_clk_i(ref_clk_i), .pin_i(pin), .a_lvl_i(a_lvl), .b_lvl_i(b_lvl),
        .trig_a_o(trig_a), .trig_b_o(trig_b), .hi_len_o(hi_len), .per_len_o(per_len));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Request held until the rising edge at which pready is sampled high; data taken there
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge ref_clk_i);
        req.penable <= 1'b1;
        @(posedge ref_clk_i);
        while (rsp.pready !== 1'b1 && n < 50) begin
            @(posedge ref_clk_i);
            n++;
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        check({31'h0, n < 50}, 32'h1);
        req <= '0;
    endtask
    task automatic wait_irq(input logic on_b, input int lim);
        int n;
        n = 0;
        got = 1'b0;
        while (!got && n < lim) begin
            @(negedge ref_clk_i);
            got = ((on_b ? irq_b : irq_a) === 1'b1);
            n++;
        end
    endtask
    task automatic cap_check(input logic in_b, input logic on_b, input logic [7:0] addr);
        logic [31:0] c0;
        xfer(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
        c0 = rd;
        if (in_b) b_lvl <= ~b_lvl;
        else a_lvl <= ~a_lvl;
        wait_irq(on_b, 50);
        check({31'h0, got}, 32'h1);
        xfer(1'b0, addr, 32'h0);
        c1 = rd;
        xfer(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
        check({31'h0, c0 < c1 && c1 < rd}, 32'h1);
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    initial begin : watchdog
        repeat (100000) @(posedge ref_clk_i);
        miscompares++;
        finish_test();
    end
    initial begin
        reset_i = 1'b1;
        req = '0;
        a_lvl = 1'b0;
        b_lvl = 1'b0;
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            check(rd, 32'h0);
        end
        xfer(1'b0, 8'h1C, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        xfer(1'b1, tcc_pkg::OFS_CC_A, 32'hFFFF_1234);
        xfer(1'b0, tcc_pkg::OFS_CC_A, 32'h0);
        check(rd, 32'h0000_1234);
        xfer(1'b1, tcc_pkg::OFS_COUNTER, 32'h0000_0055);
        xfer(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
        check(rd, 32'h0);
        // Two reads four clocks apart; code 11 never used, it only holds the counter at zero
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, tcc_pkg::OFS_PRESCALER, 32'(k));
            xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h04);
            xfer(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
            c1 = rd;
            xfer(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
            check(rd - c1, 32'h4 >> k);
            xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h00);
        end
        xfer(1'b1, tcc_pkg::OFS_PRESCALER, 32'h00);
        xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h04);
        repeat (65540) @(posedge ref_clk_i);
        xfer(1'b0, tcc_pkg::OFS_MODE_CTRL, 32'h0);
        check(rd, 32'h05);
        xfer(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
        check({31'h0, rd < 32'h40}, 32'h1);
        xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h04);
        xfer(1'b0, tcc_pkg::OFS_MODE_CTRL, 32'h0);
        check(rd, 32'h04);
        xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h00);
        xfer(1'b1, tcc_pkg::OFS_OUT_CTRL, 32'h01);
        xfer(1'b1, tcc_pkg::OFS_CC_A, 32'h40);
        xfer(1'b1, tcc_pkg::OFS_CC_B, 32'h80);
        p0 = pin;
        xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h04);
        wait_irq(1'b0, 200);
        check({31'h0, got}, 32'h1);
        @(negedge ref_clk_i);
        check({31'h0, pin}, {31'h0, ~p0});
        xfer(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
        check({31'h0, rd > 32'h40}, 32'h1);
        wait_irq(1'b1, 200);
        check({31'h0, got}, 32'h1);
        @(negedge ref_clk_i);
        check({31'h0, pin}, {31'h0, p0});
        xfer(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
        check({31'h0, rd > 32'h80}, 32'h1);
        xfer(1'b1, tcc_pkg::OFS_CAPCOMP, 32'h05);
        xfer(1'b1, tcc_pkg::OFS_PRESCALER, 32'h28);
        cap_check(1'b0, 1'b1, tcc_pkg::OFS_CC_B);
        cap_check(1'b1, 1'b0, tcc_pkg::OFS_CC_A);
        b_lvl <= 1'b0;
        a_lvl <= 1'b0;
        wait_irq(1'b0, 20);
        check({31'h0, got}, 32'h0);
        xfer(1'b1, tcc_pkg::OFS_PRESCALER, 32'h30);
        a_lvl <= ~a_lvl;
        wait_irq(1'b1, 20);
        check({31'h0, got}, 32'h0);
        // Input B edges off from here on, so the pin may be watched
        xfer(1'b1, tcc_pkg::OFS_PRESCALER, 32'h58);
        p0 = pin;
        a_lvl <= ~a_lvl;
        wait_irq(1'b1, 50);
        @(negedge ref_clk_i);
        check({30'h0, got, pin}, {30'h0, 1'b1, p0});
        xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h06);
        a_lvl <= ~a_lvl;
        wait_irq(1'b1, 50);
        @(negedge ref_clk_i);
        check({30'h0, got, pin}, {30'h0, 1'b1, ~p0});
        xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h04);
        xfer(1'b1, tcc_pkg::OFS_CAPCOMP, 32'h03);
        cap_check(1'b0, 1'b0, tcc_pkg::OFS_CC_A);
        xfer(1'b1, tcc_pkg::OFS_CAPCOMP, 32'h00);
        for (int j = 0; j < 2; j++) begin
            xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h00);
            xfer(1'b1, tcc_pkg::OFS_CC_A, j ? 32'h7 : 32'h3);
            xfer(1'b1, tcc_pkg::OFS_CC_B, j ? 32'h2 : 32'h1);
            xfer(1'b1, tcc_pkg::OFS_MODE_CTRL, 32'h0C);
            repeat (40) @(posedge ref_clk_i);
            check({16'h0, per_len}, j ? 32'h8 : 32'h4);
            check({16'h0, hi_len}, j ? 32'h3 : 32'h2);
        end
        finish_test();
    end
endmodule
`default_nettype wire

//--- tb/tcc_pins_model.sv
/*
 * Pin-side partner: drives both trigger inputs and times the output pin.
 * Assumes the bench sets the wanted trigger levels just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tcc_pins_model (
    input  wire logic        ref_clk_i,
    input  wire logic        pin_i,
    input  wire logic        a_lvl_i,
    input  wire logic        b_lvl_i,
    output logic             trig_a_o,
    output logic             trig_b_o,
    output logic [15:0]      hi_len_o,
    output logic [15:0]      per_len_o
);
    logic        prev_q   = 1'b0;
    logic [15:0] hi_cnt_q = 16'h0000;
    logic [15:0] per_cnt_q = 16'h0000;
    initial begin
        trig_a_o  = 1'b0;
        trig_b_o  = 1'b0;
        hi_len_o  = 16'h0000;
        per_len_o = 16'h0000;
    end
    // Pins are driven on the timer clock; one register stands in for board delay
    always @(posedge ref_clk_i) begin
        trig_a_o <= a_lvl_i;
        trig_b_o <= b_lvl_i;
        prev_q   <= pin_i;
        if (pin_i && !prev_q) begin
            per_len_o <= per_cnt_q;
            per_cnt_q <= 16'h0001;
        end else begin
            per_cnt_q <= per_cnt_q + 16'h0001;
        end
        if (pin_i) begin
            hi_cnt_q <= prev_q ? hi_cnt_q + 16'h0001 : 16'h0001;
        end else if (prev_q) begin
            hi_len_o <= hi_cnt_q;
        end
    end
endmodule
`default_nettype wire
